// file: hdl/pulse_cfg_defines.vh
// Constants for the command pulse input front end
// Functional notes
// - Four-bit pulse mode selects format and polarity
// - Clear input acts by level or edge
// - Alarm selector 0 clears, 1 keeps
// - Alarm selector 2 clears on alarm only
// - Filter bit selects 500 or 200 kpps
`ifndef PULSE_CFG_DEFINES_VH
`define PULSE_CFG_DEFINES_VH
`define ADDR_SETTING_ONE 4'h0
`define ADDR_ACTIVE 4'h4
`define ADDR_STATUS 4'h8
`define SETTING_RESET 16'h1011
`define F_MODE_LO 0
`define F_MODE_HI 3
`define F_CLR_LO 4
`define F_CLR_HI 5
`define F_ALM_LO 8
`define F_ALM_HI 9
`define F_FILT 12
`define MODE_LOW_BASE 4'h5
`define FMT_PULSE_DIR 4'h0
`define FMT_FWD_REV 4'h1
`define FMT_QUAD_X1 4'h2
`define FMT_QUAD_X2 4'h3
`define FMT_QUAD_X4 4'h4
`define CLR_HIGH 2'h0
`define CLR_RISE 2'h1
`define CLR_LOW 2'h2
`define CLR_FALL 2'h3
`define ALM_BOTH 2'h0
`define ALM_KEEP 2'h1
`define ALM_ONLY 2'h2
`define CLK_MHZ 250
`define KPPS_FAST 500
`define KPPS_SLOW 200
// Filter count limit: stable cycles per half pulse period, rounded down, less one
`define FILT_FAST ((`CLK_MHZ * 1000) / (2 * `KPPS_FAST) - 1)
`define FILT_SLOW ((`CLK_MHZ * 1000) / (2 * `KPPS_SLOW) - 1)
`define FILT_W 10
`endif

// file: hdl/command_pulse_input_config.v
// Command pulse decoder with deviation clear and input filter
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "pulse_cfg_defines.vh"
module command_pulse_input_config (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Avalon-MM slave
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Power-up event latching new settings
  input wire power_up,
  // Pulse pins and status inputs
  input wire pulse_a,
  input wire pulse_b,
  input wire clear_in,
  input wire alarm,
  input wire servo_on,
  // Decoded command and clear
  output reg cmd_step,
  output reg cmd_dir,
  output reg dev_clear
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers: two flops before logic
  // Bit 0 may go metastable; only bit 1 is read by logic
  // Resets low: the idle level of the clear and alarm pins and of power_up, the off level of servo_on
  // Step pins
  reg [1:0] sa;
  reg [1:0] sb;
  // Clear, alarm and energised status pins
  reg [1:0] sc;
  reg [1:0] sal;
  reg [1:0] son;
  // Power-up event
  reg [1:0] spu;

  // Shift every pin through its flop pair
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sa <= 2'h0;
      sb <= 2'h0;
      sc <= 2'h0;
      sal <= 2'h0;
      son <= 2'h0;
      spu <= 2'h0;
    end else begin
      sa <= {sa[0], pulse_a};
      sb <= {sb[0], pulse_b};
      sc <= {sc[0], clear_in};
      sal <= {sal[0], alarm};
      son <= {son[0], servo_on};
      spu <= {spu[0], power_up};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file: stored and active settings
  // Setting as last written by software
  reg [15:0] setting;
  // Setting in force, copied only at power-up
  reg [15:0] active;
  // Power-up edge detector, idle low like its pin
  reg pu_d;
  wire pu_rise;
  // Write accepted at the edge it is answered
  wire wr_take;
  assign pu_rise = spu[1] & ~pu_d;
  assign wr_take = write & ~waitrequest & (address == `ADDR_SETTING_ONE);

  // Store writes; move them into force on power-up
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      setting <= `SETTING_RESET;
      active <= `SETTING_RESET;
      pu_d <= 1'b0;
    end else begin
      // Edge detector history
      pu_d <= spu[1];
      // Only the first setting word is writable
      if (wr_take)
        setting <= writedata[15:0];
      if (pu_rise)
        active <= setting;
    end
  end

  // Bus answer: one wait cycle then data
  // Request taken while waitrequest is high
  // Next edge drops waitrequest for one cycle
  // Returning high at once stops a held strobe being taken twice
  // Readdata holds until the next read is taken
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      // Low for one cycle after a taken request
      waitrequest <= ~((read | write) & waitrequest);
      // Capture read data as the request is taken
      if (read && waitrequest) begin
        case (address)
          `ADDR_SETTING_ONE: readdata <= {16'h0, setting};
          `ADDR_ACTIVE: readdata <= {16'h0, active};
          `ADDR_STATUS: readdata <= {27'h0, dev_clear, cmd_dir, sa[1],
            sb[1], sc[1]};
          default: readdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode from the setting in force
  // A polarity change at power-up may show one edge on the step
  // lines; the host should idle at the new inactive level first
  // Pulse format and polarity
  wire [3:0] mode = active[`F_MODE_HI:`F_MODE_LO];
  // Clear input behaviour
  wire [1:0] clr_sel = active[`F_CLR_HI:`F_CLR_LO];
  // Alarm and de-energised clear behaviour
  wire [1:0] alm_sel = active[`F_ALM_HI:`F_ALM_LO];
  // Filter choice, set for the slow open-collector rate
  wire filt_sel = active[`F_FILT];
  // Codes above the low group decode to no format at all
  // low group inverts inputs
  wire inv = (mode >= `MODE_LOW_BASE);
  wire [3:0] fmt = inv ? mode - `MODE_LOW_BASE : mode;

  ////////////////////////////////////////////////////////////////////////
  // Input filter: level must hold a minimum time
  // A change passes once it stood half a period at the chosen rate
  // Shorter glitches and pulses above the rate are dropped
  localparam integer LIM_FAST = `FILT_FAST;
  localparam integer LIM_SLOW = `FILT_SLOW;
  wire [`FILT_W-1:0] flim;
  assign flim = filt_sel ? LIM_SLOW[`FILT_W-1:0] : LIM_FAST[`FILT_W-1:0];
  // Stability counters, one per step pin
  reg [`FILT_W-1:0] ca;
  reg [`FILT_W-1:0] cb;
  // Filtered levels, idle low like the synchronisers
  reg fa;
  reg fb;

  // Count while pin A differs from its filtered level
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ca <= {`FILT_W{1'b0}};
      fa <= 1'b0;
    end else begin
      if (sa[1] == fa) begin
        // Back at the filtered level: glitch discarded
        ca <= {`FILT_W{1'b0}};
      end else if (ca >= flim) begin
        // Stood long enough: accept the new level
        fa <= sa[1];
        ca <= {`FILT_W{1'b0}};
      end else begin
        ca <= ca + 1'b1;
      end
    end
  end

  // Same filter for pin B
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cb <= {`FILT_W{1'b0}};
      fb <= 1'b0;
    end else begin
      if (sb[1] == fb) begin
        // Back at the filtered level: glitch discarded
        cb <= {`FILT_W{1'b0}};
      end else if (cb >= flim) begin
        // Stood long enough: accept the new level
        fb <= sb[1];
        cb <= {`FILT_W{1'b0}};
      end else begin
        cb <= cb + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse decoding
  // Logical levels after polarity
  wire la = fa ^ inv;
  wire lb = fb ^ inv;
  // Previous logical levels for edge detection
  reg pa;
  reg pb;
  // Rising edges
  wire ra = la & ~pa;
  wire rb = lb & ~pb;
  // Any edges
  wire ea = la ^ pa;
  wire eb = lb ^ pb;
  // Decoder results for the output flops
  reg next_step;
  reg next_dir;
  always @* begin
    // No count unless the format sees one
    next_step = 1'b0;
    // Direction held by default
    next_dir = cmd_dir;
    case (fmt)
      `FMT_PULSE_DIR: begin
        // Direction line low means reverse
        next_step = ra;
        next_dir = ~lb;
      end
      `FMT_FWD_REV: begin
        // Edges on both lines at once cancel
        next_step = ra ^ rb;
        if (ra & ~rb)
          next_dir = 1'b0;
        else if (rb & ~ra)
          next_dir = 1'b1;
      end
      `FMT_QUAD_X1: begin
        // One count per A rise; B high there means reverse
        next_step = ra;
        if (ra)
          next_dir = lb;
      end
      `FMT_QUAD_X2: begin
        // One count per A edge; direction held between counts
        next_step = ea & ~eb;
        if (ea & ~eb)
          next_dir = la ^ ~lb;
      end
      `FMT_QUAD_X4: begin
        // One count per edge of either phase
        next_step = ea ^ eb;
        if (ea & ~eb)
          next_dir = ~(la ^ lb);
        else if (eb & ~ea)
          next_dir = la ^ lb;
      end
      default: begin
        next_step = 1'b0;
        next_dir = cmd_dir;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Deviation clear
  // Previous synchronised clear level
  reg pc;
  // Clear request for the output flop
  reg next_clear;

  // Clear input and alarm sources combined
  always @* begin
    next_clear = 1'b0;
    // Edge modes give a one-cycle clear
    // clear input mode
    case (clr_sel)
      `CLR_HIGH: next_clear = sc[1];
      `CLR_RISE: next_clear = sc[1] & ~pc;
      `CLR_LOW: next_clear = ~sc[1];
      `CLR_FALL: next_clear = ~sc[1] & pc;
      default: next_clear = 1'b0;
    endcase
    case (alm_sel)
      `ALM_BOTH: next_clear = next_clear | sal[1] | ~son[1];
      `ALM_ONLY: next_clear = next_clear | sal[1];
      // Selector 1 and unused code 3 keep the count
      default: next_clear = next_clear;
    endcase
  end

  // Output registers
  // Every output and edge history flop updates on each edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pa <= 1'b0;
      pb <= 1'b0;
      pc <= 1'b0;
      cmd_step <= 1'b0;
      cmd_dir <= 1'b0;
      dev_clear <= 1'b0;
    end else begin
      // Edge history
      pa <= la;
      pb <= lb;
      pc <= sc[1];
      // Registered outputs
      cmd_step <= next_step;
      cmd_dir <= next_dir;
      dev_clear <= next_clear;
    end
  end

endmodule
`default_nettype wire

// file: test/pulse_host.sv
// Host pulse generator model for the pulse pins
`timescale 1ns/1ps
`default_nettype none
module pulse_host (
  // Clock
  input wire clk,
  // Pulse pins
  output logic pulse_a,
  output logic pulse_b
);
  // Inactive pin level: low for positive, high for negative logic
  logic lvl = 1'b0;
  // Idle low
  initial {pulse_a, pulse_b} = 2'b00;
  // Park both pins at a new inactive level
  task idle(logic l);
    lvl = l;
    pulse_a <= l;
    pulse_b <= l;
    repeat (300) @(posedge clk);
  endtask
  // direction (inactive level means reverse), then pulse
  task send(logic rev, int len);
    pulse_b <= ~(rev ^ lvl);
    repeat (300) @(posedge clk);
    pulse_a <= ~lvl;
    repeat (len) @(posedge clk);
    pulse_a <= lvl;
    repeat (300) @(posedge clk);
  endtask
  // One full quadrature cycle; A leads unless reverse
  task quad(logic rev, int len);
    for (int k = 0; k < 4; k++) begin
      if ((k[0] ^ rev) == 1'b0)
        pulse_a <= ~pulse_a;
      else
        pulse_b <= ~pulse_b;
      repeat (len) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: test/pcfg_props.sv
// Checker for the pulse input front end
`timescale 1ns/1ps
`default_nettype none
module pcfg_props (
  // Watched ports
  input wire clk,
  input wire resetn,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire cmd_step
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !waitrequest |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_idl; !read && !write && waitrequest |=> waitrequest; endproperty
  a_idl: assert property (p_idl) else $error("stray answer");
  property p_fel; $fell(waitrequest) |-> $past(read) || $past(write); endproperty
  a_fel: assert property (p_fel) else $error("answer no request");
  property p_hi; !waitrequest |-> readdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_stp; cmd_step |=> !cmd_step; endproperty
  a_stp: assert property (p_stp) else $error("long step");
endmodule
bind command_pulse_input_config pcfg_props i_pcfg_props (.clk(clk),
  .resetn(resetn), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .cmd_step(cmd_step));
`default_nettype wire

// file: test/command_pulse_input_config_tb.sv
// Bench for the command pulse input front end
`timescale 1ns/1ps
`default_nettype none
module command_pulse_input_config_tb;
  logic clk, resetn, read, write, power_up, clear_in, alarm, servo_on;
  logic [3:0] address;
  logic [31:0] writedata, v, p;
  wire [31:0] readdata;
  wire waitrequest, pulse_a, pulse_b, cmd_step, cmd_dir, dev_clear;
  int err_total, tests_run, steps, clears, s0, c0;
  command_pulse_input_config i_command_pulse_input_config (.clk(clk),
    .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .power_up(power_up), .pulse_a(pulse_a), .pulse_b(pulse_b),
    .clear_in(clear_in), .alarm(alarm), .servo_on(servo_on),
    .cmd_step(cmd_step), .cmd_dir(cmd_dir), .dev_clear(dev_clear));
  pulse_host i_pulse_host (.clk(clk), .pulse_a(pulse_a), .pulse_b(pulse_b));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Count steps
  always @(posedge clk) if (cmd_step === 1'b1) steps++;
  // Count clear cycles
  always @(posedge clk) if (dev_clear === 1'b1) clears++;
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(string s, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task w;
    repeat (20) @(posedge clk);
  endtask
  // Bus cycle, read compared
  task bus(logic wr, logic [3:0] a, logic [31:0] d, string s, logic [31:0] e);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 99);
    if (waitrequest !== 1'b0) begin
      err_total++;
      test_done;
    end
    if (!wr) chk(s, e, readdata);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  // Write a setting, bring it into force, read it back
  task apply(logic [31:0] s);
    bus(1'b1, 4'h0, s, "", 32'h0);
    power_up <= 1'b1;
    w;
    power_up <= 1'b0;
    w;
    bus(1'b0, 4'h4, 32'h0, "applied", s);
  endtask
  // Main sequence
  initial begin
    {resetn, read, write, power_up, clear_in, alarm} = 6'h00;
    servo_on = 1'b1;
    address = 4'h0;
    writedata = 32'h0;
    p = 32'h1011;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0, "setting", p);
    bus(1'b0, 4'hc, 32'h0, "unmapped", 32'h0);
    bus(1'b1, 4'h4, 32'h0, "", 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = {22'h0, i[1:0], 8'h00};
      bus(1'b1, 4'h0, v, "", 32'h0);
      bus(1'b0, 4'h4, 32'h0, "held", p);
      power_up <= 1'b1;
      w;
      power_up <= 1'b0;
      w;
      bus(1'b0, 4'h4, 32'h0, "active", v);
      p = v;
      clear_in <= 1'b1;
      w;
      chk("clear", 32'h1, dev_clear);
      clear_in <= 1'b0;
      servo_on <= 1'b0;
      w;
      chk("servo off", i == 0, dev_clear);
      alarm <= 1'b1;
      w;
      chk("alarm", i != 1, dev_clear);
      servo_on <= 1'b1;
      alarm <= 1'b0;
      w;
      $display("test setting %0d done", i);
    end
    i_pulse_host.send(1'b0, 300);
    chk("fwd steps", 32'h1, steps);
    chk("fwd dir", 32'h0, cmd_dir);
    i_pulse_host.send(1'b1, 300);
    chk("rev dir", 32'h1, cmd_dir);
    i_pulse_host.send(1'b1, 100);
    chk("steps", 32'h2, steps);
    $display("test pulses done");
    // Quadrature x4, clear on rising edge, alarm keeps
    apply(32'h0114);
    s0 = steps;
    i_pulse_host.quad(1'b0, 300);
    chk("x4 fwd steps", 32'h4, steps - s0);
    chk("x4 fwd dir", 32'h0, cmd_dir);
    s0 = steps;
    i_pulse_host.quad(1'b1, 300);
    chk("x4 rev steps", 32'h4, steps - s0);
    chk("x4 rev dir", 32'h1, cmd_dir);
    c0 = clears;
    clear_in <= 1'b1;
    w;
    clear_in <= 1'b0;
    w;
    chk("rise clear", 32'h1, clears - c0);
    $display("test quad x4 done");
    // Quadrature x1 and x2, clear while low
    apply(32'h0122);
    chk("low clear", 32'h1, dev_clear);
    clear_in <= 1'b1;
    w;
    chk("low released", 32'h0, dev_clear);
    s0 = steps;
    i_pulse_host.quad(1'b0, 300);
    chk("x1 fwd steps", 32'h1, steps - s0);
    chk("x1 fwd dir", 32'h0, cmd_dir);
    s0 = steps;
    i_pulse_host.quad(1'b1, 300);
    chk("x1 rev steps", 32'h1, steps - s0);
    chk("x1 rev dir", 32'h1, cmd_dir);
    apply(32'h0123);
    s0 = steps;
    i_pulse_host.quad(1'b0, 300);
    chk("x2 fwd steps", 32'h2, steps - s0);
    chk("x2 fwd dir", 32'h0, cmd_dir);
    $display("test quad x1 x2 done");
    // Negative logic, slow filter, clear on falling edge
    i_pulse_host.idle(1'b1);
    apply(32'h1135);
    s0 = steps;
    i_pulse_host.send(1'b0, 300);
    chk("slow short steps", 32'h0, steps - s0);
    s0 = steps;
    i_pulse_host.send(1'b1, 700);
    chk("slow long steps", 32'h1, steps - s0);
    chk("neg rev dir", 32'h1, cmd_dir);
    c0 = clears;
    clear_in <= 1'b0;
    w;
    chk("fall clear", 32'h1, clears - c0);
    $display("test negative slow done");
    test_done;
  end
endmodule
`default_nettype wire
